/* rtl/edge_capture.sv */
`include "origin_seek_params.svh"

module edge_capture
  import origin_seek_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Sampled levels and their edges
  input wire logic [`EDGE_COUNT-1:0] level,
  output logic [`EDGE_COUNT-1:0] rise,
  output logic [`EDGE_COUNT-1:0] fall
);
  import origin_seek_pkg::*;

  edge_state_t st;
  edge_state_t next_st;

  // Previous level resets to each pin's idle level, so only a pin off idle at release shows an edge
  always_comb begin
    next_st = st;
    next_st.prev = level;
    next_st.rise = level & ~st.prev;
    next_st.fall = ~level & st.prev;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= {`EDGE_IDLE_LEVELS, {(2 * `EDGE_COUNT){1'b0}}};
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
  assign fall = st.fall;
endmodule

/* rtl/origin_seek_params.svh */
`ifndef ORIGIN_SEEK_PARAMS_SVH
`define ORIGIN_SEEK_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SETTING_W 16
`define POS_W 32
`define CHAN_W 3
`define CHAN_COUNT 8

// ----------------------------------------
// Seek mode codes
// ----------------------------------------
`define MODE_EDGE_A 3'h1
`define MODE_MARKER 3'h3
`define MODE_BACKOUT 3'h4
`define MODE_EDGE_B 3'h5
`define MODE_TEACH 3'h6
`define MODE_TRAVEL 3'h7

// ----------------------------------------
// Edge capture bit positions
// ----------------------------------------
`define EDGE_COUNT 6
`define EDGE_START 0
`define EDGE_ORIGIN 1
`define EDGE_TRAVEL_MINUS 2
`define EDGE_TRAVEL_PLUS 3
`define EDGE_MARKER 4
`define EDGE_RUN 5
// Travel limits idle high, every other pin idles low
`define EDGE_IDLE_LEVELS 6'h0C

// ----------------------------------------
// Reset values
// ----------------------------------------
`define POS_RESET 32'h0000_0000
`define SETTING_RESET 16'h0000
`define DIR_PLUS_SETTING 1'h1

`endif

/* rtl/origin_seek_pkg.sv */
`include "origin_seek_params.svh"

package origin_seek_pkg;

  typedef enum logic [1:0] {PROG_NONE, PROG_SEEK, PROG_AZERO} prog_cmd_t;

  typedef enum logic [3:0] {
    PH_IDLE, PH_FAST, PH_STOP, PH_BACKOUT, PH_REAPPROACH, PH_LEAVE, PH_MARKER, PH_SETTLE, PH_TEACH
  } phase_t;

  typedef enum logic [1:0] {AFT_OFFSET, AFT_MARKER, AFT_BACKOUT, AFT_FINISH} after_t;

  typedef struct packed {
    logic [2:0] mode;
    logic direction;
    logic invert;
    logic [`SETTING_W-1:0] accel;
    logic [`SETTING_W-1:0] decel;
    logic [`SETTING_W-1:0] velocity;
    logic [`SETTING_W-1:0] creep;
    logic [`POS_W-1:0] offset;
  } seek_cfg_t;

  typedef struct packed {
    logic run;
    logic dir;
    logic go;
    logic [`SETTING_W-1:0] velocity;
    logic [`SETTING_W-1:0] accel;
    logic [`SETTING_W-1:0] decel;
    logic [`POS_W-1:0] target;
  } drive_cmd_t;

  typedef struct packed {
    logic valid;
    logic [`CHAN_W-1:0] channel;
    prog_cmd_t cmd;
  } prog_write_t;

  typedef struct packed {
    logic [`EDGE_COUNT-1:0] prev;
    logic [`EDGE_COUNT-1:0] rise;
    logic [`EDGE_COUNT-1:0] fall;
  } edge_state_t;

endpackage

/* rtl/origin_seek_sequencer.sv */
// What this block does
// - Modes 1,5: origin at origin-limit rise
// - Mode 3: after limit rise and stop, take next marker
// - Mode 7: travel limit, marker after leaving
// - Servo state follows servo-on input
// - Start needs servo; direction, speeds from settings
// - Busy during seek, origin forced undefined
// - Mode 7: limit off, stop, creep out
// - Marker plus offset defines origin, flag set
// - Settled origin raises in-position and completion
// - Interrupted seek: undefined; absolute move warns
// - Program channel seek launched by run input
// - Mode 7 direction 0 uses plus limit
// - Mode 6 takes current position, no motion
// - Mode 6 completes on positioning-done conditions
// - Program zero set works with servo off
// - Sensor adjust reports displacement; backspace aborts
// - Offset applied except in mode 6 and program zero set
// - Offset teach only right after sensor adjust
// - Motor off locks servo until servo command
// - Mode 4: back out, creep back, marker
// - Zero deceleration setting uses acceleration
`include "origin_seek_params.svh"

module origin_seek_sequencer
  import origin_seek_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Discrete inputs
  input wire logic servo_on_in,
  input wire logic seek_start_in,
  input wire logic origin_limit_in,
  input wire logic travel_limit_minus_in,
  input wire logic travel_limit_plus_in,
  input wire logic marker_in,
  input wire logic run_in,
  input wire logic [`CHAN_W-1:0] program_channel_select_in,
  // Command pulses
  input wire logic seek_command,
  input wire logic sensor_adjust_command,
  input wire logic backspace_in,
  input wire logic motor_off_command,
  input wire logic servo_activate_command,
  input wire logic program_launch_command,
  input wire logic offset_teach_command,
  input wire logic abs_position_command,
  input wire origin_seek_pkg::prog_write_t prog_write,
  // Settings
  input wire origin_seek_pkg::seek_cfg_t cfg,
  // Motion feedback
  input wire logic [`POS_W-1:0] position_in,
  input wire logic motor_stopped_in,
  input wire logic positioning_done_in,
  // Status outputs
  output logic servo_state_out,
  output logic busy_out,
  output logic origin_defined_out,
  output logic in_position_out,
  output logic seek_complete_out,
  output logic origin_undefined_warning,
  output logic adjust_ready_out,
  output logic [`POS_W-1:0] origin_position_out,
  output logic [`POS_W-1:0] adjust_displacement_out,
  output logic [`POS_W-1:0] taught_offset_out,
  // Motion request
  output origin_seek_pkg::drive_cmd_t drive_out
);
  import origin_seek_pkg::*;

  typedef struct packed {
    phase_t phase;
    after_t after;
    logic busy;
    logic origin_defined;
    logic in_position;
    logic complete;
    logic servo_state;
    logic motor_locked;
    logic warning;
    logic servo_free;
    logic adjusting;
    logic adjust_ready;
    logic taught_valid;
    logic dir;
    logic [2:0] mode;
    logic [`POS_W-1:0] change_pos;
    logic [`POS_W-1:0] base;
    logic [`POS_W-1:0] origin_pos;
    logic [`POS_W-1:0] displacement;
    logic [`POS_W-1:0] taught_offset;
    logic [`CHAN_COUNT-1:0][1:0] prog;
    drive_cmd_t drive;
  } seq_state_t;

  seq_state_t st;
  seq_state_t next_st;
  logic [`EDGE_COUNT-1:0] rise;
  logic [`EDGE_COUNT-1:0] fall;

  edge_capture u_edges (
    .mclk(mclk),
    .rst(rst),
    .level({run_in, marker_in, travel_limit_plus_in, travel_limit_minus_in, origin_limit_in, seek_start_in}),
    .rise(rise),
    .fall(fall)
  );

  function automatic logic [2:0] adjust_mode(input logic [2:0] m);
    adjust_mode = (m == `MODE_BACKOUT || m == `MODE_TRAVEL) ? m : `MODE_MARKER;
  endfunction

  function automatic logic creeping(input phase_t p);
    creeping = (p == PH_BACKOUT) || (p == PH_REAPPROACH) || (p == PH_LEAVE) || (p == PH_MARKER);
  endfunction

  logic lim_fall;
  logic lim_rise;
  logic [`POS_W-1:0] offset_eff;
  logic launch;
  prog_cmd_t launch_cmd;
  logic start_seek;
  logic start_zero;
  logic start_adjust;

  // ----------------------------------------
  // Start decode
  // ----------------------------------------
  always_comb begin
    // Plus limit when direction setting is 0, raw signals active low
    lim_fall = (cfg.direction == `DIR_PLUS_SETTING) ? fall[`EDGE_TRAVEL_MINUS] : fall[`EDGE_TRAVEL_PLUS];
    lim_rise = (cfg.direction == `DIR_PLUS_SETTING) ? rise[`EDGE_TRAVEL_MINUS] : rise[`EDGE_TRAVEL_PLUS];
    offset_eff = st.taught_valid ? st.taught_offset : cfg.offset;
    launch = rise[`EDGE_RUN] || program_launch_command;
    launch_cmd = prog_cmd_t'(st.prog[program_channel_select_in]);
    start_seek = (st.phase == PH_IDLE) && st.servo_state
      && (rise[`EDGE_START] || seek_command || (launch && launch_cmd == PROG_SEEK));
    start_zero = (st.phase == PH_IDLE) && launch && launch_cmd == PROG_AZERO;
    start_adjust = (st.phase == PH_IDLE) && st.servo_state && sensor_adjust_command && !start_seek;
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.warning = abs_position_command && !st.origin_defined;
    if (prog_write.valid) begin
      next_st.prog[prog_write.channel] = prog_write.cmd;
    end
    // Motor off wins over a servo command arriving in the same cycle
    if (servo_activate_command) begin
      next_st.motor_locked = 1'b0;
    end
    if (motor_off_command) begin
      next_st.motor_locked = 1'b1;
    end
    next_st.servo_state = servo_on_in && !next_st.motor_locked;

    if (start_seek || start_adjust || start_zero) begin
      next_st.busy = 1'b1;
      next_st.origin_defined = 1'b0;
      next_st.complete = 1'b0;
      next_st.in_position = 1'b0;
      next_st.adjust_ready = 1'b0;
      next_st.adjusting = start_adjust;
      next_st.servo_free = start_zero;
      next_st.dir = cfg.direction ^ cfg.invert;
      next_st.mode = start_adjust ? adjust_mode(cfg.mode) : cfg.mode;
      next_st.phase = (start_zero || (start_seek && cfg.mode == `MODE_TEACH)) ? PH_TEACH : PH_FAST;
    end

    unique case (st.phase)
      PH_IDLE: begin
        if (offset_teach_command && st.adjust_ready) begin
          next_st.taught_offset = position_in - st.base;
          next_st.taught_valid = 1'b1;
          next_st.adjust_ready = 1'b0;
        end
      end
      PH_FAST: begin
        if (st.mode == `MODE_TRAVEL ? lim_fall : rise[`EDGE_ORIGIN]) begin
          next_st.change_pos = position_in;
          next_st.base = position_in;
          next_st.phase = PH_STOP;
          if (st.mode == `MODE_TRAVEL) begin
            next_st.after = AFT_BACKOUT;
          end else if (st.mode == `MODE_BACKOUT) begin
            next_st.after = AFT_BACKOUT;
          end else if (st.mode == `MODE_MARKER) begin
            next_st.after = AFT_MARKER;
          end else begin
            next_st.after = AFT_OFFSET;
          end
        end
      end
      PH_STOP: begin
        if (motor_stopped_in) begin
          unique case (st.after)
            AFT_BACKOUT: begin
              next_st.dir = !st.dir;
              next_st.phase = (st.mode == `MODE_TRAVEL) ? PH_LEAVE : PH_BACKOUT;
            end
            AFT_MARKER: begin
              next_st.phase = PH_MARKER;
            end
            AFT_OFFSET: begin
              next_st.drive.go = 1'b1;
              next_st.drive.target = st.base + offset_eff;
              next_st.phase = PH_SETTLE;
            end
            AFT_FINISH: begin
              next_st.busy = 1'b0;
              next_st.adjusting = 1'b0;
              next_st.adjust_ready = 1'b1;
              next_st.phase = PH_IDLE;
            end
          endcase
        end
      end
      PH_BACKOUT: begin
        if (fall[`EDGE_ORIGIN]) begin
          next_st.dir = !st.dir;
          next_st.phase = PH_REAPPROACH;
        end
      end
      PH_REAPPROACH: begin
        if (rise[`EDGE_ORIGIN]) begin
          next_st.change_pos = position_in;
          next_st.phase = PH_MARKER;
        end
      end
      PH_LEAVE: begin
        if (lim_rise) begin
          next_st.change_pos = position_in;
          next_st.phase = PH_MARKER;
        end
      end
      PH_MARKER: begin
        if (rise[`EDGE_MARKER]) begin
          next_st.base = position_in;
          next_st.displacement = position_in - st.change_pos;
          next_st.after = st.adjusting ? AFT_FINISH : AFT_OFFSET;
          next_st.phase = PH_STOP;
        end
      end
      PH_TEACH: begin
        next_st.base = position_in;
        next_st.origin_pos = position_in;
        next_st.origin_defined = 1'b1;
        next_st.busy = 1'b0;
        next_st.phase = PH_SETTLE;
      end
      PH_SETTLE: begin
        if (!st.origin_defined && motor_stopped_in) begin
          next_st.origin_pos = st.drive.target;
          next_st.origin_defined = 1'b1;
          next_st.busy = 1'b0;
        end else if (st.origin_defined && positioning_done_in) begin
          next_st.in_position = 1'b1;
          next_st.complete = 1'b1;
          next_st.phase = PH_IDLE;
        end
      end
    endcase

    // Losing the servo outside a program zero set, or a backspace, leaves the origin undefined
    if (st.phase != PH_IDLE && (backspace_in || (!st.servo_free && !st.servo_state))) begin
      next_st.phase = PH_IDLE;
      next_st.busy = 1'b0;
      next_st.origin_defined = 1'b0;
      next_st.adjusting = 1'b0;
      next_st.complete = 1'b0;
      next_st.in_position = 1'b0;
      next_st.drive.go = 1'b0;
    end

    next_st.drive.run = (next_st.phase == PH_FAST) || creeping(next_st.phase);
    next_st.drive.dir = next_st.dir;
    next_st.drive.velocity = creeping(next_st.phase) ? cfg.creep : cfg.velocity;
    next_st.drive.accel = cfg.accel;
    next_st.drive.decel = (cfg.decel == `SETTING_RESET) ? cfg.accel : cfg.decel;
    if (st.phase != PH_STOP) begin
      next_st.drive.go = next_st.drive.go && (st.phase == PH_STOP);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign servo_state_out = st.servo_state;
  assign busy_out = st.busy;
  assign origin_defined_out = st.origin_defined;
  assign in_position_out = st.in_position;
  assign seek_complete_out = st.complete;
  assign origin_undefined_warning = st.warning;
  assign adjust_ready_out = st.adjust_ready;
  assign origin_position_out = st.origin_pos;
  assign adjust_displacement_out = st.displacement;
  assign taught_offset_out = st.taught_offset;
  assign drive_out = st.drive;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_abort;
    busy_out && backspace_in;
  endsequence

  sequence s_start;
    start_seek && !start_zero && cfg.mode != `MODE_TEACH;
  endsequence

  property p_busy_undefined;
    @(posedge mclk) disable iff (rst) busy_out |-> !origin_defined_out;
  endproperty
  a_busy_undefined: assert property (p_busy_undefined) else $error("origin defined while busy");

  property p_start_edge;
    @(posedge mclk) disable iff (rst) s_start |=> busy_out && drive_out.run;
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("seek start not taken");

  property p_servo_lock;
    @(posedge mclk) disable iff (rst) (motor_off_command ##1 !servo_activate_command) |=> !servo_state_out;
  endproperty
  a_servo_lock: assert property (p_servo_lock) else $error("servo active after motor off");

  property p_servo_follow;
    @(posedge mclk) disable iff (rst)
      (servo_on_in && !st.motor_locked && !motor_off_command) |=> servo_state_out;
  endproperty
  a_servo_follow: assert property (p_servo_follow) else $error("servo state missing");

  property p_complete;
    @(posedge mclk) disable iff (rst) $rose(seek_complete_out) |-> in_position_out && origin_defined_out;
  endproperty
  a_complete: assert property (p_complete) else $error("completion without in-position");

  property p_warn;
    @(posedge mclk) disable iff (rst) (abs_position_command && !origin_defined_out) |=> origin_undefined_warning;
  endproperty
  a_warn: assert property (p_warn) else $error("missing undefined-origin warning");

  property p_abort;
    @(posedge mclk) disable iff (rst) s_abort |=> !busy_out && !origin_defined_out && !drive_out.run;
  endproperty
  a_abort: assert property (p_abort) else $error("abort left seek running");

  property p_decel;
    @(posedge mclk) disable iff (rst)
      (cfg.decel == `SETTING_RESET) |=> drive_out.decel == $past(cfg.accel);
  endproperty
  a_decel: assert property (p_decel) else $error("zero decel not replaced");

  property p_teach_still;
    @(posedge mclk) disable iff (rst) (st.phase == PH_TEACH) |-> !drive_out.run ##1 !drive_out.go;
  endproperty
  a_teach_still: assert property (p_teach_still) else $error("motion during teach");

  property p_offset;
    @(posedge mclk) disable iff (rst) drive_out.go |-> drive_out.target == st.base + offset_eff;
  endproperty
  a_offset: assert property (p_offset) else $error("offset target wrong");

  property p_travel_stop;
    @(posedge mclk) disable iff (rst)
      (st.phase == PH_FAST && st.mode == `MODE_TRAVEL && lim_fall && !backspace_in && st.servo_state)
      |=> st.phase == PH_STOP ##0 !drive_out.run;
  endproperty
  a_travel_stop: assert property (p_travel_stop) else $error("travel limit not stopping");
endmodule

/* tb/motor_partner.sv */
`include "origin_seek_params.svh"

module motor_partner
  import origin_seek_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Sequencer side
  input wire origin_seek_pkg::drive_cmd_t drive,
  input wire logic park,
  input wire logic [`POS_W-1:0] park_pos,
  // Sensors and feedback
  output logic origin_limit_in,
  output logic travel_limit_minus_in,
  output logic travel_limit_plus_in,
  output logic marker_in,
  output logic [`POS_W-1:0] position_in,
  output logic motor_stopped_in,
  output logic positioning_done_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import origin_seek_pkg::*;
  logic moving;
  logic [`POS_W-1:0] goal;
  logic [1:0] settle;
  logic signed [`POS_W-1:0] p;
  assign p = position_in;
  // Go pulse itself counts as motion, so the sequencer never sees a stale stop
  assign motor_stopped_in = !drive.run && !drive.go && !moving;
  assign positioning_done_in = motor_stopped_in && settle == 2'h3;
  assign origin_limit_in = p >= 300 && p <= 400;
  // Active low: a hit pulls the line down
  assign travel_limit_minus_in = !(p <= -200);
  assign travel_limit_plus_in = !(p >= 700);
  assign marker_in = position_in[5:0] == 6'h00;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      position_in <= '0;
      moving <= 1'h0;
      goal <= '0;
      settle <= 2'h0;
    end else begin
      if (park)
        position_in <= park_pos;
      else if (drive.run)
        position_in <= drive.dir ? position_in - 1 : position_in + 1;
      else if (moving && position_in != goal)
        position_in <= ($signed(goal) < p) ? position_in - 1 : position_in + 1;
      if (drive.go) begin
        goal <= drive.target;
        moving <= 1'h1;
      end else if (moving && position_in == goal) begin
        moving <= 1'h0;
      end
      settle <= !motor_stopped_in ? 2'h0 : (settle == 2'h3 ? settle : settle + 2'h1);
    end
  end
endmodule

/* tb/test_origin_seek_sequencer.sv */
`include "origin_seek_params.svh"

module test_origin_seek_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import origin_seek_pkg::*;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic servo_on_in = 1'h0;
  logic seek_start_in = 1'h0;
  logic run_in = 1'h0;
  logic [`CHAN_W-1:0] program_channel_select_in = '0;
  logic [7:0] cmd = 8'h00;
  prog_write_t prog_write = '0;
  seek_cfg_t cfg = '{3'h3, 1'h0, 1'h0, 16'h0100, 16'h0000, 16'h0200, 16'h0010, 32'h28};
  logic park = 1'h0;
  logic [`POS_W-1:0] park_pos = '0;
  logic origin_limit_in, travel_limit_minus_in, travel_limit_plus_in, marker_in;
  logic motor_stopped_in, positioning_done_in;
  logic servo_state_out, busy_out, origin_defined_out, in_position_out, seek_complete_out;
  logic origin_undefined_warning, adjust_ready_out;
  logic [`POS_W-1:0] position_in, origin_position_out, adjust_displacement_out, taught_offset_out;
  drive_cmd_t drive_out;
  int fails = 0;
  int checked = 0;

  always #5 mclk = ~mclk;

  origin_seek_sequencer origin_seek_sequencer_inst (
    .mclk(mclk), .rst(rst), .servo_on_in(servo_on_in), .seek_start_in(seek_start_in),
    .origin_limit_in(origin_limit_in), .travel_limit_minus_in(travel_limit_minus_in),
    .travel_limit_plus_in(travel_limit_plus_in), .marker_in(marker_in), .run_in(run_in),
    .program_channel_select_in(program_channel_select_in), .seek_command(cmd[0]),
    .sensor_adjust_command(cmd[1]), .backspace_in(cmd[2]), .motor_off_command(cmd[3]),
    .servo_activate_command(cmd[4]), .program_launch_command(cmd[5]),
    .offset_teach_command(cmd[6]), .abs_position_command(cmd[7]), .prog_write(prog_write),
    .cfg(cfg), .position_in(position_in), .motor_stopped_in(motor_stopped_in),
    .positioning_done_in(positioning_done_in), .servo_state_out(servo_state_out),
    .busy_out(busy_out), .origin_defined_out(origin_defined_out),
    .in_position_out(in_position_out), .seek_complete_out(seek_complete_out),
    .origin_undefined_warning(origin_undefined_warning), .adjust_ready_out(adjust_ready_out),
    .origin_position_out(origin_position_out), .adjust_displacement_out(adjust_displacement_out),
    .taught_offset_out(taught_offset_out), .drive_out(drive_out));

  motor_partner motor_partner_inst (
    .mclk(mclk), .rst(rst), .drive(drive_out), .park(park), .park_pos(park_pos),
    .origin_limit_in(origin_limit_in), .travel_limit_minus_in(travel_limit_minus_in),
    .travel_limit_plus_in(travel_limit_plus_in), .marker_in(marker_in),
    .position_in(position_in), .motor_stopped_in(motor_stopped_in),
    .positioning_done_in(positioning_done_in));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic near(input logic [31:0] v);
    return v[5:0] <= 6'h04 || v[5:0] >= 6'h3C;
  endfunction

  task automatic pulse(input int i);
    @(posedge mclk) cmd[i] <= 1'h1;
    @(posedge mclk) cmd[i] <= 1'h0;
  endtask

  task automatic park_to(input logic [31:0] p);
    @(posedge mclk) begin
      park <= 1'h1;
      park_pos <= p;
    end
    @(posedge mclk) park <= 1'h0;
  endtask

  // Skip a few edges first so a stale completion from the last seek is gone
  task automatic wait_done;
    int n;
    n = 0;
    repeat (4) @(posedge mclk);
    while (!(seek_complete_out === 1'h1 && busy_out === 1'h0) && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    #1;
    check("completion in time", n < 3000, 1);
  endtask

  task automatic seek(input logic [2:0] m, input logic d, input logic [31:0] off, output logic [31:0] org);
    cfg.mode <= m;
    cfg.direction <= d;
    cfg.offset <= off;
    park_to(10);
    @(posedge mclk) seek_start_in <= 1'h1;
    repeat (3) @(posedge mclk);
    #1;
    check("busy", busy_out, 1);
    check("defined while seeking", origin_defined_out, 0);
    check("run", drive_out.run, 1);
    check("dir", drive_out.dir, d);
    check("velocity", drive_out.velocity, cfg.velocity);
    check("decel", drive_out.decel, cfg.accel);
    check("accel", drive_out.accel, cfg.accel);
    wait_done();
    check("in position", in_position_out, 1);
    check("complete", seek_complete_out, 1);
    check("defined", origin_defined_out, 1);
    org = origin_position_out;
    repeat (20) @(posedge mclk);
    #1 check("no restart on level", busy_out, 0);
    @(posedge mclk) seek_start_in <= 1'h0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_servo;
    #1;
    check("idle busy", busy_out, 0);
    check("idle defined", origin_defined_out, 0);
    @(posedge mclk) servo_on_in <= 1'h1;
    repeat (3) @(posedge mclk);
    #1 check("servo on", servo_state_out, 1);
    pulse(3);
    repeat (3) @(posedge mclk);
    #1 check("locked off", servo_state_out, 0);
    pulse(4);
    repeat (3) @(posedge mclk);
    #1 check("released", servo_state_out, 1);
    $display("servo test done");
  endtask

  task automatic t_modes;
    logic [2:0] ms [6];
    logic ds [6];
    int lo [6];
    int hi [6];
    logic [31:0] org;
    logic [31:0] off;
    logic signed [31:0] b;
    ms = '{3'h1, 3'h5, 3'h3, 3'h4, 3'h7, 3'h7};
    ds = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0};
    lo = '{296, 296, 250, 250, -200, 630};
    hi = '{310, 310, 330, 330, -180, 650};
    for (int i = 0; i < 6; i++) begin
      // Travel-limit mode gets the negative offset that suits it
      off = ms[i] == 3'h7 ? 32'hFFFF_FFD8 : 32'h28;
      seek(ms[i], ds[i], off, org);
      b = org - off;
      check("origin place", b >= lo[i] && b <= hi[i], 1);
      if (i > 1)
        check("on marker", near(b), 1);
    end
    $display("mode test done");
  endtask

  task automatic t_teach;
    cfg.mode <= 3'h6;
    park_to(500);
    @(posedge mclk) seek_start_in <= 1'h1;
    wait_done();
    check("taught origin", origin_position_out, 500);
    check("no motion", position_in, 500);
    check("settled", positioning_done_in, 1);
    @(posedge mclk) seek_start_in <= 1'h0;
    $display("teach test done");
  endtask

  task automatic t_abort;
    cfg.mode <= 3'h3;
    cfg.invert <= 1'h1;
    park_to(10);
    pulse(0);
    repeat (50) @(posedge mclk);
    #1 check("busy", busy_out, 1);
    check("inverted dir", drive_out.dir, 1);
    pulse(2);
    repeat (2) @(posedge mclk);
    #1;
    check("aborted busy", busy_out, 0);
    check("aborted defined", origin_defined_out, 0);
    check("aborted run", drive_out.run, 0);
    cfg.invert <= 1'h0;
    pulse(7);
    #1 check("warning", origin_undefined_warning, 1);
    $display("abort test done");
  endtask

  task automatic t_program;
    cfg.mode <= 3'h1;
    park_to(10);
    @(posedge mclk) begin
      prog_write <= '{1'h1, 3'h5, PROG_SEEK};
      program_channel_select_in <= 3'h5;
    end
    @(posedge mclk) prog_write.valid <= 1'h0;
    @(posedge mclk) run_in <= 1'h1;
    wait_done();
    check("program seek", origin_defined_out, 1);
    @(posedge mclk) run_in <= 1'h0;
    @(posedge mclk) servo_on_in <= 1'h0;
    park_to(123);
    @(posedge mclk) begin
      prog_write <= '{1'h1, 3'h2, PROG_AZERO};
      program_channel_select_in <= 3'h2;
    end
    @(posedge mclk) prog_write.valid <= 1'h0;
    #1 check("servo off", servo_state_out, 0);
    pulse(5);
    wait_done();
    check("zero set", origin_position_out, 123);
    @(posedge mclk) servo_on_in <= 1'h1;
    $display("program test done");
  endtask

  task automatic t_adjust;
    logic signed [31:0] v;
    cfg.mode <= 3'h3;
    park_to(10);
    pulse(6);
    #1 check("teach refused", taught_offset_out, 0);
    pulse(1);
    for (int n = 0; n < 3000 && adjust_ready_out !== 1'h1; n++)
      @(posedge mclk);
    #1;
    v = adjust_displacement_out;
    check("displacement", (v >= 10 && v <= 26) || (v >= -50 && v <= -40), 1);
    check("adjust idle", busy_out, 0);
    park_to(400);
    pulse(6);
    #1;
    v = taught_offset_out;
    check("taught offset", v >= 70 && v <= 150, 1);
    check("ready cleared", adjust_ready_out, 0);
    $display("adjust test done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    repeat (2) @(posedge mclk);
    t_servo();
    t_modes();
    t_teach();
    t_abort();
    t_program();
    t_adjust();
    final_report();
  end

  // Whole run needs some 3 500 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    final_report();
  end
endmodule
